// file: hw/mmru_map.svh
// Purpose: register offsets, field values, limits and timing of the request unit
// Assumes: 40 MHz clock
// Notes:   byte addresses on a 32-bit classic wishbone slave
`ifndef MMRU_MAP_SVH
`define MMRU_MAP_SVH
// register byte offsets
`define MMRU_A_CTRL    8'h00
`define MMRU_A_REQ     8'h04
`define MMRU_A_SREF    8'h08
`define MMRU_A_LOCAL   8'h0c
`define MMRU_A_COUNT   8'h10
`define MMRU_A_EXBUF   8'h14
`define MMRU_A_TMO     8'h18
`define MMRU_A_STAT    8'h1c
`define MMRU_A_PADDR   8'h20
// control bits
`define MMRU_B_START   0
`define MMRU_B_WRITE   1
`define MMRU_B_EXT     2
// port identity of the second serial port
`define MMRU_PORT_ID   8'h02
// station limits
`define MMRU_STN_MAX   8'hf7
`define MMRU_STN_ZERO  8'h00
// function codes
`define MMRU_FC_RCOIL  8'h01
`define MMRU_FC_RINP   8'h02
`define MMRU_FC_RHOLD  8'h03
`define MMRU_FC_RIREG  8'h04
`define MMRU_FC_WCOIL  8'h05
`define MMRU_FC_WREG   8'h06
`define MMRU_FC_REXC   8'h07
`define MMRU_FC_DIAG   8'h08
`define MMRU_FC_WCOILS 8'h0f
`define MMRU_FC_WREGS  8'h10
// slave reference windows
`define MMRU_R_ONE     19'h00001
`define MMRU_R_COIL_S  19'h003e7
`define MMRU_R_INP_SL  19'h003e9
`define MMRU_R_INP_SH  19'h007cf
`define MMRU_R_HLD_SL  19'h00fa1
`define MMRU_R_HLD_SH  19'h01387
`define MMRU_R_IRG_SL  19'h00bb9
`define MMRU_R_IRG_SH  19'h00f9f
`define MMRU_R_COIL_E  19'h0ffff
`define MMRU_R_INP_EL  19'h02711
`define MMRU_R_INP_EH  19'h04e1f
`define MMRU_R_INP_XL  19'h186a1
`define MMRU_R_INP_XH  19'h2869f
`define MMRU_R_HLD_EL  19'h09c41
`define MMRU_R_HLD_EH  19'h0c34f
`define MMRU_R_HLD_XL  19'h61a81
`define MMRU_R_HLD_XH  19'h71a7f
`define MMRU_R_IRG_EL  19'h07531
`define MMRU_R_IRG_EH  19'h09c3f
`define MMRU_R_IRG_XL  19'h493e1
`define MMRU_R_IRG_XH  19'h593df
// element counts
`define MMRU_CNT_ONE   12'h001
`define MMRU_CNT_BITS  12'h7d0
`define MMRU_CNT_REGS  12'h07d
// local destination areas and their highest address
`define MMRU_AREA_IO   3'h0
`define MMRU_AREA_REL  3'h1
`define MMRU_AREA_TC   3'h2
`define MMRU_LIM_IO    16'h03ff
`define MMRU_LIM_REL   16'h07ff
`define MMRU_LIM_TC    16'h00ff
// reject and failure causes
`define MMRU_C_NONE    4'h0
`define MMRU_C_PORT    4'h1
`define MMRU_C_STN     4'h2
`define MMRU_C_FUNC    4'h3
`define MMRU_C_SREF    4'h4
`define MMRU_C_CNT     4'h5
`define MMRU_C_DEST    4'h6
`define MMRU_C_TMO     4'h7
`define MMRU_C_EXC     4'h8
`define MMRU_C_LINK    4'h9
// response timeout
`define MMRU_TMO_MS    500
`define MMRU_CLK_KHZ   40000
`endif

// file: hw/mmru_pkg.sv
// Purpose: types of the request unit
// Assumes: nothing
// Notes:   constants live in mmru_map.svh
package mmru_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_REQ, ST_FETCH, ST_MWAIT, ST_MCAP, ST_FEED, ST_WAIT, ST_EXC
  } mmru_state_t;
  typedef struct packed {
    logic        ok;
    logic [3:0]  cause;
    logic        has_addr;
    logic [15:0] paddr;
    logic [11:0] cnt;
  } mmru_chk_t;
endpackage

// file: hw/mmru_unit.sv
// Purpose: modbus master request unit of the second serial port
// Assumes: framer handles crc and timing; local memory answers a read one cycle later
// Notes:   software programs the request registers and writes the start bit
//
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "mmru_map.svh"

// Functional notes
// - accept only port identity of second port
// - read station must be 1 through 247
// - read codes 01 02 03 04 07 only
// - write station must be 0 through 247
// - write codes 05 06 08 15 16 only
// - count used only by codes 01, 02, 03, 04, 15, 16
// - bits 1-2000, registers 1-125 per transfer
// - format bit selects short or extended ranges
// - coil read reference ranges per format
// - input read reference ranges per format
// - holding read reference ranges per format
// - input register read ranges per format
// - exception status read sends no address
// - single coil force reference ranges
// - single register preset reference ranges
// - multiple coil force reference ranges
// - multiple register preset reference ranges
// - read destination within its local area
// - write data fetched from consecutive local words
// - exception stored at exception buffer word
// - busy flag held for whole transaction
// - error flag set on fault, cleared on start
// - response timeout logs communication error
// - master only during a transaction, else slave
module mmru_unit
  import mmru_pkg::*;
#(
  parameter logic [24:0] TMO_CYCLES = 25'(`MMRU_TMO_MS * `MMRU_CLK_KHZ)
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // request to framer
  output logic             req_valid_o,
  input  wire logic        req_ready_i,
  output logic      [7:0]  req_func_o,
  output logic      [7:0]  req_station_o,
  output logic             req_has_addr_o,
  output logic      [15:0] req_addr_o,
  output logic      [11:0] req_count_o,
  // outgoing write data
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  output logic      [15:0] tx_data_o,
  // response from framer
  input  wire logic        rx_valid_i,
  input  wire logic [15:0] rx_data_i,
  input  wire logic        rsp_done_i,
  input  wire logic        rsp_exc_i,
  input  wire logic [7:0]  rsp_exc_code_i,
  input  wire logic        rsp_err_i,
  // local memory
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic      [15:0] mem_addr_o,
  output logic      [15:0] mem_wdata_o,
  input  wire logic [15:0] mem_rdata_i,
  // status
  output logic             port_busy_flag_o,
  output logic             port_error_flag_o,
  output logic             master_mode_o
);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  function automatic logic inr(input logic [18:0] v, input logic [18:0] lo,
                               input logic [18:0] hi);
    inr = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      wmerge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
    end
  endfunction

  // request check and reference decode
  function automatic mmru_chk_t check(input logic wr, input logic ext,
                                      input logic [7:0] fc, input logic [7:0] stn,
                                      input logic [7:0] port, input logic [18:0] sref,
                                      input logic [11:0] cnt, input logic [2:0] area,
                                      input logic [15:0] dst);
    mmru_chk_t   r;
    logic [18:0] lo1;
    logic [18:0] hi1;
    logic [18:0] lo2;
    logic [18:0] hi2;
    logic [18:0] base;
    logic        fc_ok;
    logic        bits;
    logic        multi;
    logic [15:0] lim;
    r = '0;
    lo1 = `MMRU_R_ONE;
    hi1 = ext ? `MMRU_R_COIL_E : `MMRU_R_COIL_S;
    lo2 = lo1;
    hi2 = hi1;
    bits = 1'b1;
    multi = 1'b1;
    r.has_addr = 1'b1;
    if (wr) begin
      fc_ok = fc inside {`MMRU_FC_WCOIL, `MMRU_FC_WREG, `MMRU_FC_DIAG,
                         `MMRU_FC_WCOILS, `MMRU_FC_WREGS};
    end else begin
      fc_ok = fc inside {`MMRU_FC_RCOIL, `MMRU_FC_RINP, `MMRU_FC_RHOLD,
                         `MMRU_FC_RIREG, `MMRU_FC_REXC};
    end
    case (fc)
      `MMRU_FC_RINP: begin
        lo1 = ext ? `MMRU_R_INP_EL : `MMRU_R_INP_SL;
        hi1 = ext ? `MMRU_R_INP_EH : `MMRU_R_INP_SH;
        lo2 = ext ? `MMRU_R_INP_XL : lo1;
        hi2 = ext ? `MMRU_R_INP_XH : hi1;
      end
      `MMRU_FC_RHOLD, `MMRU_FC_WREG, `MMRU_FC_WREGS: begin
        lo1 = ext ? `MMRU_R_HLD_EL : `MMRU_R_HLD_SL;
        hi1 = ext ? `MMRU_R_HLD_EH : `MMRU_R_HLD_SH;
        lo2 = ext ? `MMRU_R_HLD_XL : lo1;
        hi2 = ext ? `MMRU_R_HLD_XH : hi1;
        bits = 1'b0;
      end
      `MMRU_FC_RIREG: begin
        lo1 = ext ? `MMRU_R_IRG_EL : `MMRU_R_IRG_SL;
        hi1 = ext ? `MMRU_R_IRG_EH : `MMRU_R_IRG_SH;
        lo2 = ext ? `MMRU_R_IRG_XL : lo1;
        hi2 = ext ? `MMRU_R_IRG_XH : hi1;
        bits = 1'b0;
      end
      `MMRU_FC_REXC, `MMRU_FC_DIAG: begin
        r.has_addr = 1'b0;
        multi = 1'b0;
      end
      default: begin
        bits = 1'b1;
      end
    endcase
    if (wr && !(fc inside {`MMRU_FC_WCOILS, `MMRU_FC_WREGS})) begin
      multi = 1'b0;
    end
    r.cnt = multi ? cnt : `MMRU_CNT_ONE;
    base = inr(sref, lo2, hi2) && ext ? lo2 : lo1;
    r.paddr = r.has_addr ? 16'(sref - base) : sref[15:0];
    case (area)
      `MMRU_AREA_IO:  lim = `MMRU_LIM_IO;
      `MMRU_AREA_REL: lim = `MMRU_LIM_REL;
      `MMRU_AREA_TC:  lim = `MMRU_LIM_TC;
      default:        lim = 16'hffff;
    endcase
    if (port != `MMRU_PORT_ID) begin
      r.cause = `MMRU_C_PORT;
    end else if ((!wr && stn == `MMRU_STN_ZERO) || stn > `MMRU_STN_MAX) begin
      r.cause = `MMRU_C_STN;
    end else if (!fc_ok) begin
      r.cause = `MMRU_C_FUNC;
    end else if (r.has_addr && !inr(sref, lo1, hi1) && !inr(sref, lo2, hi2)) begin
      r.cause = `MMRU_C_SREF;
    end else if (multi && (cnt == 12'h000 ||
                 cnt > (bits ? `MMRU_CNT_BITS : `MMRU_CNT_REGS))) begin
      r.cause = `MMRU_C_CNT;
    end else if (!wr && 17'(dst) + 17'(r.cnt) - 17'h00001 > {1'b0, lim}) begin
      r.cause = `MMRU_C_DEST;
    end else begin
      r.ok = 1'b1;
    end
    return r;
  endfunction

  // software registers
  logic        wr_q;
  logic        ext_q;
  logic [23:0] req_q;
  logic [18:0] sref_q;
  logic [18:0] local_q;
  logic [11:0] cnt_cfg_q;
  logic [15:0] exbuf_cfg_q;
  logic [24:0] tmo_cfg_q;
  logic        pend_q;
  logic [3:0]  cause_q;
  logic [7:0]  exc_q;
  logic [15:0] paddr_q;
  // transaction state
  mmru_state_t state_q;
  logic        cur_wr_q;
  logic [15:0] maddr_q;
  logic [15:0] exbuf_q;
  logic [11:0] cnt_q;
  logic [11:0] idx_q;
  logic [24:0] tmo_q;
  mmru_chk_t   chk;
  logic        bus_req;
  logic        bus_wr;
  logic [31:0] wd;
  logic        ev_start;
  logic        ev_reject;
  logic        ev_tmo;
  logic        ev_fail;
  logic        ev_end;

  assign chk = check(wr_q, ext_q, req_q[7:0], req_q[15:8], req_q[23:16], sref_q,
                     cnt_cfg_q, local_q[18:16], local_q[15:0]);
  assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr    = bus_req && wb_we_i;
  assign wd        = wmerge(32'h0000_0000, wb_dat_i, wb_sel_i);
  assign ev_start  = state_q == ST_IDLE && pend_q && chk.ok;
  assign ev_reject = state_q == ST_IDLE && pend_q && !chk.ok;
  assign ev_tmo    = state_q == ST_WAIT && !rsp_done_i && !rsp_err_i && tmo_q == 25'h0;
  assign ev_fail   = ev_tmo || (state_q == ST_WAIT && rsp_err_i && !rsp_done_i);
  assign ev_end    = ev_fail || state_q == ST_EXC ||
                     (state_q == ST_WAIT && rsp_done_i && !rsp_exc_i);

  // register writes and read-back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0000_0000;
      wr_q        <= 1'b0;
      ext_q       <= 1'b0;
      req_q       <= 24'h000000;
      sref_q      <= 19'h00000;
      local_q     <= 19'h00000;
      cnt_cfg_q   <= 12'h000;
      exbuf_cfg_q <= 16'h0000;
      tmo_cfg_q   <= TMO_CYCLES;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h0000_0000;
      if (bus_wr) begin
        case (wb_adr_i)
          `MMRU_A_CTRL: if (wb_sel_i[0]) begin
            wr_q  <= wd[`MMRU_B_WRITE];
            ext_q <= wd[`MMRU_B_EXT];
          end
          `MMRU_A_REQ:   req_q       <= 24'(wmerge({8'h00, req_q}, wb_dat_i, wb_sel_i));
          `MMRU_A_SREF:  sref_q      <= 19'(wmerge({13'h0, sref_q}, wb_dat_i, wb_sel_i));
          `MMRU_A_LOCAL: local_q     <= 19'(wmerge({13'h0, local_q}, wb_dat_i, wb_sel_i));
          `MMRU_A_COUNT: cnt_cfg_q   <= 12'(wmerge({20'h0, cnt_cfg_q}, wb_dat_i, wb_sel_i));
          `MMRU_A_EXBUF: exbuf_cfg_q <= 16'(wmerge({16'h0, exbuf_cfg_q}, wb_dat_i, wb_sel_i));
          `MMRU_A_TMO:   tmo_cfg_q   <= 25'(wmerge({7'h0, tmo_cfg_q}, wb_dat_i, wb_sel_i));
          default: ;
        endcase
      end else if (bus_req) begin
        case (wb_adr_i)
          `MMRU_A_CTRL:  wb_dat_o <= {29'h0, ext_q, wr_q, pend_q};
          `MMRU_A_REQ:   wb_dat_o <= {8'h00, req_q};
          `MMRU_A_SREF:  wb_dat_o <= {13'h0, sref_q};
          `MMRU_A_LOCAL: wb_dat_o <= {13'h0, local_q};
          `MMRU_A_COUNT: wb_dat_o <= {20'h0, cnt_cfg_q};
          `MMRU_A_EXBUF: wb_dat_o <= {16'h0, exbuf_cfg_q};
          `MMRU_A_TMO:   wb_dat_o <= {7'h0, tmo_cfg_q};
          `MMRU_A_STAT:  wb_dat_o <= {16'h0, exc_q, cause_q, pend_q, master_mode_o,
                                      port_error_flag_o, port_busy_flag_o};
          `MMRU_A_PADDR: wb_dat_o <= {16'h0, paddr_q};
          default:       wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // start request held until the unit is idle, set wins over consume
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
    end else if (bus_wr && wb_adr_i == `MMRU_A_CTRL && wb_sel_i[0] && wd[`MMRU_B_START]) begin
      pend_q <= 1'b1;
    end else if (state_q == ST_IDLE) begin
      pend_q <= 1'b0;
    end
  end

  // transaction sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q        <= ST_IDLE;
      cur_wr_q       <= 1'b0;
      maddr_q        <= 16'h0000;
      exbuf_q        <= 16'h0000;
      cnt_q          <= 12'h000;
      idx_q          <= 12'h000;
      tmo_q          <= 25'h0;
      paddr_q        <= 16'h0000;
      req_valid_o    <= 1'b0;
      req_func_o     <= 8'h00;
      req_station_o  <= 8'h00;
      req_has_addr_o <= 1'b0;
      req_addr_o     <= 16'h0000;
      req_count_o    <= 12'h000;
      tx_valid_o     <= 1'b0;
      tx_data_o      <= 16'h0000;
    end else begin
      case (state_q)
        ST_IDLE: if (ev_start) begin
          cur_wr_q       <= wr_q;
          maddr_q        <= local_q[15:0];
          exbuf_q        <= exbuf_cfg_q;
          cnt_q          <= chk.cnt;
          idx_q          <= 12'h000;
          paddr_q        <= chk.paddr;
          req_valid_o    <= 1'b1;
          req_func_o     <= req_q[7:0];
          req_station_o  <= req_q[15:8];
          req_has_addr_o <= chk.has_addr;
          req_addr_o     <= chk.paddr;
          req_count_o    <= chk.cnt;
          state_q        <= ST_REQ;
        end
        ST_REQ: if (req_ready_i) begin
          req_valid_o <= 1'b0;
          tmo_q       <= tmo_cfg_q;
          state_q     <= cur_wr_q ? ST_FETCH : ST_WAIT;
        end
        ST_FETCH: state_q <= ST_MWAIT;
        ST_MWAIT: state_q <= ST_MCAP;
        ST_MCAP: begin
          tx_data_o  <= mem_rdata_i;
          tx_valid_o <= 1'b1;
          state_q    <= ST_FEED;
        end
        ST_FEED: if (tx_ready_i) begin
          tx_valid_o <= 1'b0;
          idx_q      <= idx_q + 12'h001;
          tmo_q      <= tmo_cfg_q;
          state_q    <= (idx_q + 12'h001 == cnt_q) ? ST_WAIT : ST_FETCH;
        end
        ST_WAIT: begin
          tmo_q <= tmo_q - 25'h1;
          if (rx_valid_i && !cur_wr_q) begin
            idx_q <= idx_q + 12'h001;
          end
          if (rsp_done_i && rsp_exc_i) begin
            state_q <= ST_EXC;
          end else if (ev_end) begin
            state_q <= ST_IDLE;
          end
        end
        ST_EXC: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // local memory port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_rd_o    <= 1'b0;
      mem_wr_o    <= 1'b0;
      mem_addr_o  <= 16'h0000;
      mem_wdata_o <= 16'h0000;
    end else begin
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      if (state_q == ST_FETCH) begin
        mem_rd_o   <= 1'b1;
        mem_addr_o <= maddr_q + {4'h0, idx_q};
      end else if (state_q == ST_WAIT && rx_valid_i && !cur_wr_q) begin
        mem_wr_o    <= 1'b1;
        mem_addr_o  <= maddr_q + {4'h0, idx_q};
        mem_wdata_o <= rx_data_i;
      end else if (state_q == ST_WAIT && rsp_done_i && rsp_exc_i) begin
        mem_wr_o    <= 1'b1;
        mem_addr_o  <= exbuf_q;
        mem_wdata_o <= {8'h00, rsp_exc_code_i};
      end
    end
  end

  // busy, error and mode flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_busy_flag_o  <= 1'b0;
      master_mode_o     <= 1'b0;
      port_error_flag_o <= 1'b0;
      cause_q           <= `MMRU_C_NONE;
      exc_q             <= 8'h00;
    end else begin
      if (ev_start) begin
        port_busy_flag_o  <= 1'b1;
        master_mode_o     <= 1'b1;
        port_error_flag_o <= 1'b0;
        cause_q           <= `MMRU_C_NONE;
      end else if (ev_end) begin
        port_busy_flag_o <= 1'b0;
        master_mode_o    <= 1'b0;
      end
      if (ev_reject) begin
        port_error_flag_o <= 1'b1;
        cause_q           <= chk.cause;
      end else if (ev_fail) begin
        port_error_flag_o <= 1'b1;
        cause_q           <= ev_tmo ? `MMRU_C_TMO : `MMRU_C_LINK;
      end else if (state_q == ST_WAIT && rsp_done_i && rsp_exc_i) begin
        port_error_flag_o <= 1'b1;
        cause_q           <= `MMRU_C_EXC;
        exc_q             <= rsp_exc_code_i;
      end
    end
  end

  // checks
  port_match_a: assert property (ev_start |-> req_q[23:16] == `MMRU_PORT_ID)
    else $error("request started for a foreign port");
  rd_station_a: assert property (ev_start && !wr_q |-> ##1 req_station_o inside {[1:247]})
    else $error("read station outside 1..247");
  rd_func_a: assert property (ev_start && !wr_q |=> req_func_o inside {1, 2, 3, 4, 7})
    else $error("illegal read function issued");
  wr_station_a: assert property (ev_start && wr_q |=> req_station_o <= 8'd247)
    else $error("write station above 247");
  wr_func_a: assert property (ev_start && wr_q |=> req_func_o inside {5, 6, 8, 15, 16})
    else $error("illegal write function issued");
  single_cnt_a: assert property (req_valid_o && cur_wr_q && req_func_o inside {5, 6, 8}
                                 |-> req_count_o == 12'd1)
    else $error("single write not limited to one item");
  cnt_lim_a: assert property (req_valid_o && req_func_o inside {1, 2, 15}
                              |-> req_count_o inside {[1:2000]})
    else $error("bit count out of range");
  noaddr_exc_a: assert property (req_valid_o && req_func_o == 8'd7 |-> !req_has_addr_o)
    else $error("exception status read carries an address");
  exc_store_a: assert property (state_q == ST_WAIT && rsp_done_i && rsp_exc_i
                                |=> mem_wr_o && mem_addr_o == exbuf_q)
    else $error("exception not stored at buffer");
  busy_hold_a: assert property (port_busy_flag_o == (state_q != ST_IDLE))
    else $error("busy differs from transaction state");
  err_clear_a: assert property (ev_start |=> !port_error_flag_o)
    else $error("error flag not cleared on start");
  tmo_err_a: assert property (ev_tmo |=> port_error_flag_o && !port_busy_flag_o
                              && cause_q == `MMRU_C_TMO)
    else $error("timeout not logged");
  mode_busy_a: assert property (master_mode_o == port_busy_flag_o)
    else $error("master mode differs from busy");
  one_txn_a: assert property ($rose(req_valid_o) |-> !$past(port_busy_flag_o))
    else $error("request launched while busy");
  fetch_seq_a: assert property (state_q == ST_FETCH |=> mem_rd_o
                                && mem_addr_o == 16'(maddr_q + {4'h0, idx_q}))
    else $error("write data fetched from wrong word");

endmodule // mmru_unit

// file: test/mmru_peer.sv
// Purpose: framer and local memory stand-in
// Assumes: mode 0 answers, 1 exception, 2 silent, 3 link error
// Notes:   memory reads return address xor 5a5a
`timescale 1ns/1ps
module mmru_peer (
  // clock and control
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [1:0]  mode_i,
  // framer side
  input  wire logic        rv_i,
  input  wire logic [7:0]  fc_i,
  input  wire logic [11:0] cnt_i,
  input  wire logic        tv_i,
  input  wire logic [15:0] td_i,
  output logic             rr_o,
  output logic             tr_o,
  output logic             xv_o,
  output logic      [15:0] xd_o,
  output logic             dn_o,
  output logic             ex_o,
  output logic             er_o,
  // memory side
  input  wire logic        mrd_i,
  input  wire logic        mwr_i,
  input  wire logic [15:0] ma_i,
  input  wire logic [15:0] mw_i,
  output logic      [15:0] mr_o,
  // observations
  output int               tn_o,
  output logic      [15:0] tl_o,
  output logic      [31:0] wl_o
);
  int   rx_left;
  int   tx_left;
  logic busy_q;
  always_ff @(posedge clk_i) begin
    xv_o <= 1'b0;
    dn_o <= 1'b0;
    ex_o <= 1'b0;
    er_o <= 1'b0;
    rr_o <= rv_i & ~rr_o & ~busy_q & ~rst_i;
    tr_o <= tv_i & ~tr_o & ~rst_i;
    mr_o <= mrd_i ? (ma_i ^ 16'h5a5a) : ~mr_o;
    if (mwr_i)
      wl_o <= {ma_i, mw_i};
    if (rst_i) begin
      busy_q <= 1'b0;
      rx_left <= 0;
      tx_left <= 0;
      tn_o <= 0;
      xd_o <= 16'h0000;
    end else if (rv_i && rr_o) begin
      busy_q <= 1'b1;
      rx_left <= (fc_i >= 8'h05 && fc_i != 8'h07) ? 0 : 2;
      tx_left <= (fc_i >= 8'h05 && fc_i != 8'h07) ? int'(cnt_i) : 0;
    end else if (busy_q) begin
      if (tv_i && tr_o) begin
        tx_left <= tx_left - 1;
        tn_o <= tn_o + 1;
        tl_o <= td_i;
      end else if (rx_left > 0) begin
        xv_o <= 1'b1;
        xd_o <= xd_o + 16'h1357;
        rx_left <= rx_left - 1;
      end else if (tx_left == 0 && mode_i != 2'h2) begin
        dn_o <= (mode_i != 2'h3);
        er_o <= (mode_i == 2'h3);
        ex_o <= (mode_i == 2'h1);
        busy_q <= 1'b0;
      end
    end
  end
endmodule // mmru_peer

// file: test/modbus_master_request_unit_bench.sv
// Purpose: self-checking bench of the request unit
// Assumes: timeout parameter shortened to 100 cycles
// Notes:   expected causes and addresses come from the range rules
`timescale 1ns/1ps
module modbus_master_request_unit_bench;
  logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]  wb_adr_i = 0, req_func_o, req_station_o;
  logic [31:0] wb_dat_i = 0, wb_dat_o, wl, d, seed = 32'h7fdaa7cd;
  logic        wb_ack_o, req_valid_o, req_ready_i, req_has_addr_o, tx_valid_o, tx_ready_i;
  logic        rx_valid_i, rsp_done_i, rsp_exc_i, mem_rd_o, mem_wr_o, master_mode_o;
  logic        port_busy_flag_o, port_error_flag_o, rsp_err_i;
  logic [15:0] req_addr_o, tx_data_o, rx_data_i, mem_addr_o, mem_wdata_o, mem_rdata_i, tl;
  logic [11:0] req_count_o;
  logic [1:0]  mode = 0;
  int          n_fail = 0, num_checks = 0, tn, t0;
  always #12.5 clk_i = ~clk_i;
  mmru_unit #(.TMO_CYCLES(25'd100)) DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .req_valid_o, .req_ready_i,
    .req_func_o, .req_station_o, .req_has_addr_o, .req_addr_o, .req_count_o, .tx_valid_o,
    .tx_ready_i, .tx_data_o, .rx_valid_i, .rx_data_i, .rsp_done_i, .rsp_exc_i,
    .rsp_exc_code_i(8'h02), .rsp_err_i, .mem_rd_o, .mem_wr_o, .mem_addr_o, .mem_wdata_o,
    .mem_rdata_i, .port_busy_flag_o, .port_error_flag_o, .master_mode_o);
  mmru_peer PEER (.clk_i, .rst_i, .mode_i(mode), .rv_i(req_valid_o), .fc_i(req_func_o),
    .cnt_i(req_count_o), .tv_i(tx_valid_o), .td_i(tx_data_o), .rr_o(req_ready_i),
    .tr_o(tx_ready_i), .xv_o(rx_valid_i), .xd_o(rx_data_i), .dn_o(rsp_done_i), .ex_o(rsp_exc_i),
    .er_o(rsp_err_i), .mrd_i(mem_rd_o), .mwr_i(mem_wr_o), .ma_i(mem_addr_o), .mw_i(mem_wdata_o),
    .mr_o(mem_rdata_i), .tn_o(tn), .tl_o(tl), .wl_o(wl));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= v;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    d = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk_i);
    if (k >= 20) begin
      n_fail++;
      finish_test;
    end
  endtask
  // wx: bit1 extended format, bit0 write
  task automatic run(input logic [1:0] wx, input logic [7:0] fc, input logic [7:0] st,
      input logic [7:0] pt, input logic [18:0] sr, input logic [18:0] lc,
      input logic [11:0] cn, input logic [3:0] ca, input logic [15:0] pa);
    int k;
    k = 0;
    wb(1, 8'h04, {8'h00, pt, st, fc});
    wb(1, 8'h08, {13'h0, sr});
    wb(1, 8'h0c, {13'h0, lc});
    wb(1, 8'h10, {20'h0, cn});
    wb(1, 8'h00, {29'h0, wx, 1'b1});
    do begin
      wb(0, 8'h1c, 32'h0);
      chk(d[2], d[0]);
      k++;
    end while ((d[0] | d[3]) && k < 500);
    if (k >= 500) begin
      n_fail++;
      finish_test;
    end
    chk(d[1], ca != 4'h0);
    if (ca != 4'h0) chk(d[7:4], ca);
    else begin
      chk(req_station_o, st);
      chk(req_count_o, (fc inside {8'h05, 8'h06, 8'h07, 8'h08}) ? 12'h001 : cn);
      chk(req_has_addr_o, fc != 8'h07 && fc != 8'h08);
      if (fc != 8'h07) begin
        wb(0, 8'h20, 32'h0);
        chk(d, pa);
        chk(req_addr_o, pa);
      end
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, 8'h18, 32'h0);
    chk(d, 32'd100);
    wb(0, 8'h3c, 32'h0);
    chk(d, 32'h0);
    run(2, 8'h03, 1, 2, 40001, 19'h30000, 2, 0, 0);
    run(0, 8'h01, 247, 2, 999, 19'h30000, 2000, 0, 998);
    run(0, 8'h01, 1, 2, 1, 19'h30000, 2001, 5, 0);
    run(2, 8'h03, 1, 2, 40001, 19'h30000, 126, 5, 0);
    run(2, 8'h03, 0, 2, 40001, 19'h30000, 1, 2, 0);
    run(2, 8'h03, 248, 2, 40001, 19'h30000, 1, 2, 0);
    run(2, 8'h03, 1, 3, 40001, 19'h30000, 1, 1, 0);
    run(0, 8'h05, 1, 2, 1, 19'h30000, 1, 3, 0);
    run(1, 8'h03, 1, 2, 4001, 19'h30000, 1, 3, 0);
    run(2, 8'h02, 1, 2, 100001, 19'h30000, 1, 0, 0);
    run(0, 8'h02, 1, 2, 2000, 19'h30000, 1, 4, 0);
    run(0, 8'h04, 1, 2, 3001, 19'h30000, 1, 0, 0);
    run(2, 8'h04, 1, 2, 30000, 19'h30000, 1, 4, 0);
    run(0, 8'h07, 1, 2, 0, 19'h30000, 1, 0, 0);
    run(2, 8'h01, 1, 2, 1, 19'h200ff, 2, 6, 0);
    run(2, 8'h01, 1, 2, 1, 19'h200fe, 2, 0, 0);
    run(1, 8'h06, 0, 2, 4999, 19'h30000, 1, 0, 998);
    run(1, 8'h05, 1, 2, 1000, 19'h30000, 1, 4, 0);
    run(3, 8'h0f, 1, 2, 65535, 19'h30000, 3, 0, 65534);
    run(1, 8'h08, 1, 2, 0, 19'h30000, 1, 0, 0);
    t0 = tn;
    run(3, 8'h10, 1, 2, 400001, 19'h30010, 2, 0, 0);
    chk(tn - t0, 2);
    chk(tl, 16'h0011 ^ 16'h5a5a);
    seed = lfsr(seed);
    wb(1, 8'h14, {16'h0, seed[15:0]});
    mode <= 2'h1;
    run(2, 8'h03, 1, 2, 40001, 19'h30000, 1, 8, 0);
    chk(wl, {seed[15:0], 16'h0002});
    chk(d[15:8], 8'h02);
    mode <= 2'h3;
    run(2, 8'h03, 1, 2, 40001, 19'h30000, 1, 9, 0);
    mode <= 2'h2;
    run(2, 8'h03, 1, 2, 40001, 19'h30000, 1, 7, 0);
    finish_test;
  end
endmodule // modbus_master_request_unit_bench
